// [hdl/audio_embed_mixer.sv]
// Audio embed mixer: control registers, delay, gain, routing and metering
//
// The Avalon-MM register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module audio_embed_mixer #(
    parameter int DEPTH = audio_mix_pkg::DLY_DEPTH
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire audio_mix_pkg::vid_meas_t vid_meas,
    input wire logic laser_ok,
    input wire audio_mix_pkg::aes_in_t [3:0] aes_in,
    input wire logic [3:0] grp_present,
    input wire audio_mix_pkg::aud_t aud_in,
    output audio_mix_pkg::aud_t aud_out,
    output audio_mix_pkg::embed_t embed
);
    import audio_mix_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam int PW = 28;
    localparam int SW = 31;

    // ========================================================================
    // State
    typedef struct packed {
        cfg_t cfg;
        logic [9:0] dly_ms;
        ch_cfg_t [NUM_CH-1:0] ch;
        logic [NUM_CH-1:0] peak;
        vu_t [NUM_CH-1:0] vu;
        logic ack;
        logic [31:0] rdata;
        logic [AW-1:0] wptr;
        logic d1_valid;
        logic d1_zero;
        logic [NUM_CH-1:0][SMP_W-1:0] d1_byp;
        logic d2_valid;
        logic [NUM_CH-1:0][PW-1:0] d2;
        aud_t out;
        embed_t emb;
    } st_t;

    st_t st;
    st_t nxt;

    // ========================================================================
    // Helper functions
    function automatic logic [7:0] ch_addr(input int i);
        return REG_CH_BASE + 8'(4 * i);
    endfunction

    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (old & ~m) | (wd & m);
    endfunction

    // Gain in whole dB to unsigned Q3.16; 6 dB is taken as one octave
    function automatic logic [18:0] db_to_lin(input logic signed [7:0] db);
        logic [6:0] e;
        logic [3:0] k;
        logic [2:0] r;
        e = 7'(int'(db) + GAIN_BIAS_DB);
        k = 4'(e / 7'd6);
        r = 3'(e % 7'd6);
        return 19'(GAIN_MANT[r]) << k;
    endfunction

    function automatic logic signed [7:0] clamp_gain(input logic signed [7:0] g);
        if (int'(g) > GAIN_MAX_DB) return 8'(GAIN_MAX_DB);
        if (int'(g) < GAIN_MIN_DB) return 8'(GAIN_MIN_DB);
        return g;
    endfunction

    function automatic logic [SMP_W-1:0] sat24(input logic signed [SW-1:0] s);
        if (s > SW'(24'sh7fffff)) return 24'h7fffff;
        if (s < -SW'(25'sh0800000)) return 24'h800000;
        return s[SMP_W-1:0];
    endfunction

    function automatic logic [3:0] sel_mask(input logic [2:0] sel);
        return (sel >= 3'h1 && sel <= 3'h4) ? 4'(4'h1 << (sel - 3'h1)) : 4'h0;
    endfunction

    function automatic grp_stat_t grp_status(input logic [2:0] sel);
        if (sel_mask(sel) == 4'h0) return GS_OFF;
        if ((sel_mask(sel) & grp_present) == 4'h0) return GS_NONE;
        return grp_stat_t'(sel + 3'h1);
    endfunction

    function automatic vfmt_t classify_vid(input vid_meas_t v);
        if (!v.lock) return VF_NONE;
        case (v.lines)
            LINES_525: return v.interlaced ? VF_SD525 : VF_UNKNOWN;
            LINES_625: return v.interlaced ? VF_SD625 : VF_UNKNOWN;
            LINES_750: begin
                case (v.rate)
                    FR_50: return VF_720P50;
                    FR_5994: return VF_720P5994;
                    FR_60: return VF_720P60;
                    default: return VF_UNKNOWN;
                endcase
            end
            LINES_1125: begin
                if (v.interlaced) begin
                    case (v.rate)
                        FR_50: return VF_1080I50;
                        FR_5994: return VF_1080I5994;
                        FR_60: return VF_1080I60;
                        default: return VF_UNKNOWN;
                    endcase
                end
                case (v.rate)
                    FR_25: return v.psf ? VF_1080SF25 : VF_1080P25;
                    FR_2398: return v.psf ? VF_1080SF2398 : VF_1080P2398;
                    FR_24: return v.psf ? VF_1080SF24 : VF_1080P24;
                    default: return VF_UNKNOWN;
                endcase
            end
            default: return VF_UNKNOWN;
        endcase
    endfunction

    function automatic aes_stat_t classify_aes(input aes_in_t a);
        if (!a.present) return AS_NONE;
        if (a.nonaudio) return a.sync ? AS_SYNC_DATA : AS_ASYNC_DATA;
        return a.sync ? AS_SYNC_AUDIO : AS_ASYNC_AUDIO;
    endfunction

    // ========================================================================
    // Status and channel decode
    logic [NUM_CH-1:0] dat;
    grp_stat_t grp_a;
    grp_stat_t grp_b;
    logic [31:0] status_word;
    logic acc;

    // Each AES pair feeds two adjacent channels; a nonaudio pair makes both of them data channels
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            dat[i] = aes_in[i / 2].nonaudio;
        end
    end

    assign grp_a = grp_status(st.cfg.sel_a);
    assign grp_b = grp_status(st.cfg.sel_b);
    assign status_word = {9'h000,
                          classify_aes(aes_in[3]), classify_aes(aes_in[2]),
                          classify_aes(aes_in[1]), classify_aes(aes_in[0]),
                          grp_b, grp_a, classify_vid(vid_meas), laser_ok};

    // Bus: one wait cycle, then the answer; frozen clock enable keeps it waiting
    assign acc = (avs_read || avs_write) && st.ack && ce;
    assign avs_waitrequest = (avs_read || avs_write) && !acc;
    assign avs_readdata = st.rdata;
    assign aud_out = st.out;
    assign embed = st.emb;

    // ========================================================================
    // Delay memory, read before write so a full-depth delay is exact
    logic [NUM_CH*SMP_W-1:0] dly_mem [DEPTH];
    logic [NUM_CH*SMP_W-1:0] mem_q;
    logic [AW-1:0] rd_addr;
    logic [31:0] dly_s;

    always_comb begin
        dly_s = 32'(st.dly_ms) * SAMPLE_KHZ;
        if (dly_s > 32'(DEPTH)) begin
            dly_s = 32'(DEPTH);
        end
        rd_addr = (32'(st.wptr) >= dly_s) ? AW'(32'(st.wptr) - dly_s)
                                          : AW'(32'(st.wptr) + 32'(DEPTH) - dly_s);
    end

    always_ff @(posedge clk) begin
        if (ce && aud_in.valid) begin
            dly_mem[st.wptr] <= aud_in.smp;
            mem_q <= dly_mem[rd_addr];
        end
    end

    // ========================================================================
    // Next-state logic
    logic [31:0] cur_word;
    logic [31:0] merged;
    ch_cfg_t wch;
    logic signed [7:0] g;
    logic [NUM_CH-1:0][SMP_W-1:0] d1_s;
    logic signed [43:0] prod;
    logic signed [PW-1:0] p;
    logic signed [SW-1:0] sum;
    logic [SMP_W-1:0] so;
    logic [24:0] mag;
    logic [2:0] psel;

    always_comb begin
        nxt = st;
        wch = '0;
        g = '0;
        prod = '0;
        p = '0;
        sum = '0;
        so = '0;
        mag = '0;
        psel = (st.cfg.peak_sel > PEAK_SEL_MAX) ? PEAK_SEL_MAX : st.cfg.peak_sel;
        d1_s = st.d1_zero ? st.d1_byp : mem_q;

        // Addressed register as it stands; unmapped reads zero
        case (avs_address)
            REG_CONFIG: cur_word = 32'(st.cfg);
            REG_DELAY: cur_word = 32'(st.dly_ms);
            REG_STATUS: cur_word = status_word;
            REG_METER: cur_word = {8'h00, st.vu, st.peak};
            default: cur_word = 32'h0;
        endcase
        for (int i = 0; i < NUM_CH; i++) begin
            if (avs_address == ch_addr(i)) begin
                cur_word = 32'(st.ch[i]);
            end
        end
        merged = be_merge(cur_word, avs_writedata, avs_byteenable);
        nxt.ack = (avs_read || avs_write) && !st.ack;
        nxt.rdata = avs_read ? cur_word : 32'h0;

        // Register writes
        if (acc && avs_write) begin
            case (avs_address)
                REG_CONFIG: nxt.cfg = cfg_t'(merged[11:0]);
                REG_DELAY: nxt.dly_ms = (merged > 32'(DELAY_MAX_MS)) ? 10'(DELAY_MAX_MS)
                                                                  : merged[9:0];
                REG_METER: nxt.peak = st.peak & ~(avs_writedata[7:0] & {8{avs_byteenable[0]}});
                default: nxt.cfg = st.cfg;
            endcase
            for (int i = 0; i < NUM_CH; i++) begin
                // Data channels lock out their controls
                if (avs_address == ch_addr(i) && !dat[i]) begin
                    wch = ch_cfg_t'(merged[13:0]);
                    g = wch.dflt ? GAIN_RST : clamp_gain(wch.gain_db);
                    nxt.ch[i] = wch;
                    nxt.ch[i].dflt = 1'b0;
                    nxt.ch[i].gain_db = g;
                    if (wch.tie && !wch.dflt) begin
                        for (int j = 0; j < NUM_CH; j++) begin
                            if (j != i && st.ch[j].tie && !dat[j]) begin
                                nxt.ch[j].gain_db = g;
                            end
                        end
                    end
                end
            end
        end

        // Embedder control, derived from configuration
        nxt.emb.insert_mask = sel_mask(st.cfg.sel_a) | sel_mask(st.cfg.sel_b);
        nxt.emb.remove_mask = st.cfg.strip ? 4'hf
                            : (st.cfg.cascade ? 4'h0
                            : nxt.emb.insert_mask);
        nxt.emb.append = st.cfg.cascade;
        nxt.emb.strip_all = st.cfg.strip;

        // Stage 1: delay write pointer and zero-delay bypass
        nxt.d1_valid = aud_in.valid;
        if (aud_in.valid) begin
            nxt.d1_zero = (dly_s == 32'h0);
            nxt.d1_byp = aud_in.smp;
            nxt.wptr = (32'(st.wptr) == DEPTH - 1) ? '0 : AW'(st.wptr + 1'b1);
        end

        // Stage 2: gain and polarity, data passes untouched
        nxt.d2_valid = st.d1_valid;
        if (st.d1_valid) begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (dat[i]) begin
                    nxt.d2[i] = {{(PW - SMP_W){d1_s[i][SMP_W-1]}}, d1_s[i]};
                end else begin
                    prod = signed'(d1_s[i]) * signed'({1'b0, db_to_lin(st.ch[i].gain_db)});
                    p = prod[GAIN_FRAC+PW-1:GAIN_FRAC];
                    nxt.d2[i] = st.ch[i].invert ? -p : p;
                end
            end
        end

        // Stage 3: route, sum, saturate and meter; a peak set beats a clear
        nxt.out.valid = st.d2_valid;
        if (st.d2_valid) begin
            for (int o = 0; o < NUM_CH; o++) begin
                sum = '0;
                for (int i = 0; i < NUM_CH; i++) begin
                    if (!dat[i] && st.ch[i].route == 3'(o)) begin
                        sum = sum + SW'(signed'(st.d2[i]));
                    end
                end
                so = dat[o] ? st.d2[o][SMP_W-1:0] : sat24(sum);
                nxt.out.smp[o] = so;
                mag = so[SMP_W-1] ? 25'(25'h1000000 - {1'b0, so}) : {1'b0, so};
                if (!dat[o]) begin
                    if (mag > {1'b0, PEAK_THR[psel]}) begin
                        nxt.peak[o] = 1'b1;
                    end
                    nxt.vu[o] = (mag > {1'b0, VU_0_THR[st.cfg.ref18]}) ? VU_HIGH
                              : (mag > {1'b0, VU_M20_THR[st.cfg.ref18]}) ? VU_NOMINAL
                              : VU_OFF;
                end else begin
                    nxt.vu[o] = VU_OFF;
                end
            end
        end
    end

    // ========================================================================
    // State register; all configuration resets to zero, which is unity gain
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else if (ce) begin
            st <= nxt;
        end
    end

    // ========================================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    chk_bus_answer: assert property (
        (avs_read || avs_write) && !st.ack && ce ##1 (ce && (avs_read || avs_write))
        |-> !avs_waitrequest
    ) else $error("bus request not answered after one wait cycle");

    chk_delay_bound: assert property (
        st.dly_ms <= 10'(DELAY_MAX_MS)
    ) else $error("audio delay above its maximum");

    chk_pipe_latency: assert property (
        aud_in.valid && ce ##1 ce ##1 ce |=> aud_out.valid
    ) else $error("sample did not leave three enabled cycles later");

    chk_replace_mode: assert property (
        !st.emb.strip_all && !st.emb.append |-> st.emb.remove_mask == st.emb.insert_mask
    ) else $error("replace mode does not remove the targeted groups");

    chk_append_mode: assert property (
        st.emb.append && !st.emb.strip_all |-> st.emb.remove_mask == 4'h0
    ) else $error("cascade mode removes existing audio");

    chk_strip_all: assert property (
        ce && st.cfg.strip |=> st.emb.remove_mask == 4'hf && st.emb.strip_all
    ) else $error("strip does not remove all groups");

    chk_peak_hold: assert property (
        ce && st.peak[0] && !(acc && avs_write && avs_address == REG_METER) |=> st.peak[0]
    ) else $error("peak flag dropped without a clear");

    chk_gain_default: assert property (
        acc && avs_write && avs_address == ch_addr(3) && avs_byteenable[1]
        && avs_writedata[13] && !dat[3] |=> st.ch[3].gain_db == GAIN_RST
    ) else $error("default did not restore unity gain");

    chk_tie_follow: assert property (
        acc && avs_write && avs_address == ch_addr(3) && avs_byteenable[1]
        && avs_writedata[12] && !avs_writedata[13] && st.ch[2].tie && !dat[2] && !dat[3]
        |=> st.ch[2].gain_db == st.ch[3].gain_db
    ) else $error("tied channel did not follow gain");

    chk_gain_range: assert property (
        int'(st.ch[0].gain_db) >= GAIN_MIN_DB && int'(st.ch[0].gain_db) <= GAIN_MAX_DB
    ) else $error("channel gain out of range");

    chk_group_off: assert property (
        sel_mask(st.cfg.sel_a) == 4'h0 |-> grp_a == GS_OFF
    ) else $error("unselected group not reported off");
endmodule

// [hdl/audio_mix_pkg.sv]
// Package of constants, register layout and types for the audio embed mixer
// ============================================================================
package audio_mix_pkg;
    // ========================================================================
    // Sizes and timing
    localparam int NUM_CH = 8;
    localparam int SMP_W = 24;
    localparam int GAIN_FRAC = 16;
    localparam int GAIN_BIAS_DB = 72;
    localparam int GAIN_MIN_DB = -70;
    localparam int GAIN_MAX_DB = 12;
    localparam int SAMPLE_KHZ = 48;
    localparam int DELAY_MAX_MS = 1000;
    localparam int DLY_DEPTH = DELAY_MAX_MS * SAMPLE_KHZ;

    // ========================================================================
    // Register byte addresses and reset values
    localparam logic [7:0] REG_CONFIG = 8'h00;
    localparam logic [7:0] REG_DELAY = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_METER = 8'h0c;
    localparam logic [7:0] REG_CH_BASE = 8'h10;
    localparam logic [7:0] GAIN_RST = 8'h00;
    localparam logic [2:0] PEAK_SEL_MAX = 3'h5;

    // ========================================================================
    // Lookup tables: gain mantissa per dB step, level thresholds
    localparam logic [5:0][7:0] GAIN_MANT = {8'h1c, 8'h19, 8'h17, 8'h14, 8'h12, 8'h10};
    localparam logic [5:0][23:0] PEAK_THR = {24'h287a01, 24'h32f52c, 24'h4026e5,
                                             24'h50c32f, 24'h65acc5, 24'h7ffffe};
    localparam logic [1:0][23:0] VU_0_THR = {24'h101d46, 24'h0ccccd};
    localparam logic [1:0][23:0] VU_M20_THR = {24'h019c87, 24'h0147ae};

    // Total lines per frame of the known rasters
    localparam logic [10:0] LINES_525 = 11'h20d;
    localparam logic [10:0] LINES_625 = 11'h271;
    localparam logic [10:0] LINES_750 = 11'h2ee;
    localparam logic [10:0] LINES_1125 = 11'h465;

    // ========================================================================
    // Enumerations
    typedef enum logic [3:0] {
        VF_NONE, VF_720P50, VF_720P5994, VF_720P60, VF_1080I50, VF_1080I5994,
        VF_1080I60, VF_1080P25, VF_1080P2398, VF_1080P24, VF_1080SF25,
        VF_1080SF2398, VF_1080SF24, VF_SD525, VF_SD625, VF_UNKNOWN
    } vfmt_t;
    typedef enum logic [2:0] {
        FR_2398, FR_24, FR_25, FR_2997, FR_30, FR_50, FR_5994, FR_60
    } rate_t;
    typedef enum logic [2:0] {
        AS_NONE, AS_SYNC_AUDIO, AS_ASYNC_AUDIO, AS_SYNC_DATA, AS_ASYNC_DATA
    } aes_stat_t;
    typedef enum logic [2:0] {GS_OFF, GS_NONE, GS_G1, GS_G2, GS_G3, GS_G4} grp_stat_t;
    typedef enum logic [1:0] {VU_OFF, VU_NOMINAL, VU_HIGH} vu_t;

    // ========================================================================
    // Register layouts, low bit last
    typedef struct packed {
        logic [2:0] sel_b;
        logic [2:0] sel_a;
        logic [2:0] peak_sel;
        logic ref18;
        logic strip;
        logic cascade;
    } cfg_t;
    typedef struct packed {
        logic dflt;
        logic tie;
        logic invert;
        logic [2:0] route;
        logic signed [7:0] gain_db;
    } ch_cfg_t;

    // ========================================================================
    // Carriers
    typedef struct packed {
        logic lock;
        logic [10:0] lines;
        logic interlaced;
        logic psf;
        rate_t rate;
    } vid_meas_t;
    typedef struct packed {
        logic present;
        logic sync;
        logic nonaudio;
    } aes_in_t;
    typedef struct packed {
        logic valid;
        logic [NUM_CH-1:0][SMP_W-1:0] smp;
    } aud_t;
    typedef struct packed {
        logic [3:0] insert_mask;
        logic [3:0] remove_mask;
        logic append;
        logic strip_all;
    } embed_t;
endpackage

// [testbench/aes_source_model.sv]
// Far-side model: video measurement, AES pair states, sample strobes
`timescale 1ns/100ps
module aes_source_model (
    input wire logic clk,
    input wire logic send,
    input wire logic [7:0][23:0] smp,
    output audio_mix_pkg::vid_meas_t vid_meas,
    output audio_mix_pkg::aes_in_t [3:0] aes_in,
    output audio_mix_pkg::aud_t aud_in
);
    import audio_mix_pkg::*;
    // Locked SD 525 source; pairs: sync audio, async audio, sync data, none
    assign vid_meas = '{1'b1, LINES_525, 1'b1, 1'b0, FR_5994};
    assign aes_in = {3'b000, 3'b111, 3'b100, 3'b110};
    // Samples scramble between strobes so nothing leans on stale values
    initial aud_in = '0;
    always @(posedge clk) begin
        aud_in.valid <= send;
        aud_in.smp <= send ? smp : ~aud_in.smp;
    end
endmodule

// [testbench/tb_audio_embed_mixer.sv]
// Self-checking bench for the audio embed mixer
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
module tb_audio_embed_mixer;
    import audio_mix_pkg::*;
    logic clk = 0;
    logic reset_n = 0;
    logic avs_read = 0;
    logic avs_write = 0;
    logic send = 0;
    logic laser_ok = 1;
    logic [3:0] avs_byteenable = 4'hf;
    logic [7:0] avs_address = '0;
    logic [31:0] avs_writedata = '0;
    logic [31:0] avs_readdata;
    logic [31:0] q;
    logic avs_waitrequest;
    logic [7:0][23:0] smp = '0;
    logic [7:0][23:0] exp;
    vid_meas_t vid_meas;
    aes_in_t [3:0] aes_in;
    aud_t aud_in;
    aud_t aud_out;
    embed_t embed;
    int failures = 0;
    int comparisons = 0;

    // Short delay memory keeps the run brief
    audio_embed_mixer #(.DEPTH(480)) audio_embed_mixer_i (.clk(clk), .reset_n(reset_n),
        .ce(1'b1), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .vid_meas(vid_meas), .laser_ok(laser_ok),
        .aes_in(aes_in), .grp_present(4'h1), .aud_in(aud_in), .aud_out(aud_out),
        .embed(embed));
    aes_source_model aes_source_model_i (.clk(clk), .send(send), .smp(smp),
        .vid_meas(vid_meas), .aes_in(aes_in), .aud_in(aud_in));

    initial forever #10 clk = ~clk;

    // =====
    // Bus and stream tasks; request held until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        // Sampled at the rising edge, where the write lands and read data stands
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) failures++;
        q = avs_readdata;
        avs_read <= 0;
        avs_write <= 0;
    endtask

    task automatic push(input logic [7:0][23:0] v);
        int n;
        n = 0;
        @(posedge clk);
        smp <= v;
        send <= 1;
        @(posedge clk);
        send <= 0;
        do begin
            @(negedge clk);
            n++;
        end while (aud_out.valid !== 1'b1 && n < 10);
        if (n >= 10) failures++;
    endtask

    // =====
    // Scenarios
    task automatic t_status();
        bus(0, REG_CONFIG, 0);
        `CHK("config", 32'h0, q)
        bus(0, REG_STATUS, 0);
        `CHK("status", {9'h0, AS_NONE, AS_SYNC_DATA, AS_ASYNC_AUDIO, AS_SYNC_AUDIO,
            GS_OFF, GS_OFF, VF_SD525, 1'b1}, q)
        bus(1, REG_CONFIG, 32'h640);
        bus(0, REG_STATUS, 0);
        `CHK("groups", {GS_NONE, GS_G1}, q[10:5])
        laser_ok <= 0;
        bus(0, REG_STATUS, 0);
        `CHK("laser", 1'b0, q[0])
        laser_ok <= 1;
    endtask

    // Group 1 and 3 chosen; low bits walk replace, cascade, strip
    task automatic t_embed();
        embed_t e;
        for (int i = 0; i < 3; i++) begin
            bus(1, REG_CONFIG, 32'h640 | i);
            e = '{4'h5, (i == 2) ? 4'hf : (i == 1) ? 4'h0 : 4'h5, i == 1, i == 2};
            repeat (2) @(negedge clk);
            `CHK("embed", e, embed)
        end
    endtask

    // Channel 0 inverted to output 1; 1 and 2 sum past full scale; pair 2 is data
    task automatic t_mix();
        bus(1, REG_CH_BASE, 32'h900);
        exp = '0;
        exp[0] = 24'h7fffff;
        exp[1] = 24'hedcbaa;
        exp[4] = 24'h800001;
        exp[5] = 24'h5a5a5a;
        push({48'h0, 24'h5a5a5a, 24'h800001, 24'h0, 24'h000100, 24'h7fffff, 24'h123456});
        `CHK("mix", exp, aud_out.smp)
        bus(0, REG_METER, 0);
        `CHK("meter", {1'b1, 2'(VU_HIGH)}, {q[0], q[9:8]})
        bus(1, REG_METER, 32'hff);
        bus(0, REG_METER, 0);
        `CHK("peak clear", 8'h0, q[7:0])
    endtask

    // 6 dB headroom and -18 reference: levels that fail with less headroom or with the -20 reference
    task automatic t_levels();
        logic [7:0][23:0] v;
        bus(1, REG_CONFIG, 32'h1c);
        v = '0;
        v[0] = 24'h0f0000;
        v[1] = 24'h4026e6;
        push(v);
        bus(0, REG_METER, 0);
        `CHK("levels", {2'b01, 2'(VU_NOMINAL), 2'(VU_HIGH)}, {q[1:0], q[11:8]})
    endtask

    task automatic t_limits();
        bus(1, REG_DELAY, 32'h3ff);
        bus(0, REG_DELAY, 0);
        `CHK("delay max", 10'(DELAY_MAX_MS), q[9:0])
        bus(1, REG_CH_BASE + 8'h8, 32'h14);
        bus(0, REG_CH_BASE + 8'h8, 0);
        `CHK("gain max", 8'(GAIN_MAX_DB), q[7:0])
        bus(1, REG_CH_BASE + 8'h8, 32'h9c);
        bus(0, REG_CH_BASE + 8'h8, 0);
        `CHK("gain min", 8'(GAIN_MIN_DB), q[7:0])
        avs_byteenable <= 4'h2;
        bus(1, REG_CH_BASE + 8'h8, 32'h0f07);
        avs_byteenable <= 4'hf;
        bus(0, REG_CH_BASE + 8'h8, 0);
        `CHK("lanes", 32'h0fba, q)
        bus(1, REG_CH_BASE + 8'h8, 32'h1003);
        bus(1, REG_CH_BASE + 8'hc, 32'h1005);
        bus(0, REG_CH_BASE + 8'h8, 0);
        `CHK("tie", 8'h05, q[7:0])
        bus(1, REG_CH_BASE + 8'hc, 32'h2000);
        bus(0, REG_CH_BASE + 8'hc, 0);
        `CHK("default", 8'h00, q[7:0])
        bus(1, REG_CH_BASE + 8'h10, 32'h6);
        bus(0, REG_CH_BASE + 8'h10, 0);
        `CHK("data gain", 32'h0, q)
        bus(0, 8'hfc, 0);
        `CHK("unmapped", 32'h0, q)
    endtask

    // One millisecond is 48 strobes at 48 kHz
    task automatic t_delay();
        logic [7:0][23:0] v;
        bus(1, REG_DELAY, 32'h1);
        for (int k = 0; k <= 48; k++) begin
            v = '0;
            v[1] = 24'(k + 1);
            push(v);
        end
        `CHK("delay", 24'h1, aud_out.smp[0])
    endtask

    task automatic summarize();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1;
        t_status();
        t_embed();
        t_mix();
        t_levels();
        t_limits();
        t_delay();
        summarize();
    end

    // Whole run needs well under 1500 cycles
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        summarize();
    end
endmodule
